// *** design/stim_pkg.sv ***
package stim_pkg;
  // output port width
  localparam int          NUM_OUTPUTS     = 8;
  // command encodings
  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_SET_ONE,
    CMD_CLEAR_ONE,
    CMD_WRITE_ALL
  } cmd_t;
  // reset values
  localparam logic [7:0]  OUTPUTS_RESET   = 8'h00;
  localparam logic        STROBE_N_RESET  = 1'h1;
  // strobe width in nanoseconds and the clock period in nanoseconds
  localparam int          STROBE_NS       = 4000;
  localparam int          CLK_PERIOD_NS   = 4;
  // least time: round up, at least one cycle
  localparam int          STROBE_CYCLES   =
    ((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          STROBE_CNT_W    = $clog2(STROBE_CYCLES + 1);
endpackage : stim_pkg

// *** design/strobe_if.sv ***
`timescale 1ns/1ps
// carries a change event to the strobe generator and its pulse back
interface strobe_if;
  logic change;   // one-cycle pulse: an output changed level
  logic busy;     // strobe currently low
  modport src  (output change, input busy);
  modport gen  (input change, output busy);
endinterface : strobe_if

// *** design/strobe_gen.sv ***
`timescale 1ns/1ps
// low pulse of fixed width, restarted by each change
module strobe_gen #(
  parameter int CYCLES = stim_pkg::STROBE_CYCLES
) (
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  strobe_if.gen       sif,
  output logic        strobe_n
);
  localparam int W = $clog2(CYCLES + 1);
  // refuse a width the counter cannot serve
  if (CYCLES < 1) begin : g_bad_width
    $error("strobe width must be at least one cycle");
  end
  logic [W-1:0] cnt_r;    // cycles of low left
  logic [W-1:0] cnt_nxt;
  logic         str_r;    // registered strobe level
  logic         str_nxt;

  // reload on change so the pulse always lasts the full width
  always_comb begin
    cnt_nxt = cnt_r;
    str_nxt = 1'b1;
    if (sif.change) begin
      cnt_nxt = W'(CYCLES - 1);
      str_nxt = 1'b0;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
      str_nxt = 1'b0;
    end
  end

  // register stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      str_r <= stim_pkg::STROBE_N_RESET;
    end else begin
      cnt_r <= cnt_nxt;
      str_r <= str_nxt;
    end
  end
  assign strobe_n = str_r;
  assign sif.busy = ~str_r;

  // a change loads the width less one (CYCLES - 1) and drives the strobe low
  a_strobe_start: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    sif.change |=> !str_r && cnt_r == W'(CYCLES - 1))
    else $error("strobe not started on change");
  // the strobe stays low while cycles are left
  a_strobe_width: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !str_r && cnt_r != '0 |=> !str_r)
    else $error("strobe ended early");
  // with no new change the strobe rises once the count is spent
  a_strobe_end: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !str_r && cnt_r == '0 && !sif.change |=> str_r)
    else $error("strobe held too long");
endmodule : strobe_gen

// *** design/stimulus_output_generator.sv ***
`timescale 1ns/1ps
// What this block does
// - eight latched outputs hold last commanded level
// - single-bit command sets or clears one output
// - byte bit n drives output n
// - byte write updates all outputs together
// - any change pulses strobe low 4 us
// - grouped single-bit commands run in order
// - supports static levels, pulses, repeating patterns

// commands arrive one per clock while cmd_valid is high and are never
// refused, so a group of single-bit commands lands in issue order
// a byte write replaces all eight outputs at one clock edge, so the
// target never sees a half-written pattern
// the strobe fires only when a level really changes; a command that
// leaves the outputs as they were gives no pulse
// every change restarts the strobe, so a burst of changes gives one
// long low pulse that ends a full width after the last change
// pulses and repeating patterns are built by the host from command
// sequences; the block itself keeps no pattern memory
module stimulus_output_generator #(
  parameter int STROBE_CYCLES = stim_pkg::STROBE_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire stim_pkg::cmd_t    cmd,
  input  wire logic              cmd_valid,
  input  wire logic [2:0]        cmd_index,
  input  wire logic [7:0]        cmd_byte,
  output logic                   cmd_ready,
  output logic [7:0]             stim_out,
  output logic                   change_strobe_n
);
  // refuse a strobe width the counter cannot serve
  if (STROBE_CYCLES < 1) begin : g_bad_width
    $error("strobe width must be positive");
  end

  // reset synchroniser: asserts at once, releases two edges later
  logic       rst_s1_r;   // first stage, read only by second
  logic       rst_n_r;    // second stage
  logic       rst_n;      // synchronised reset for the rest
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0; // asynchronous assert
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1; // release ripples through both stages
      rst_n_r  <= rst_s1_r;
    end
  end
  assign rst_n = rst_n_r;

  strobe_if   sif();
  logic [7:0] out_r;      // latched outputs
  logic [7:0] out_nxt;
  logic [7:0] bit_mask;   // one-hot of the commanded index

  // one command per cycle, always accepted, so order is kept
  assign cmd_ready = 1'b1;
  assign bit_mask  = 8'h01 << cmd_index;

  // next output value from the command
  always_comb begin
    out_nxt = out_r;
    if (cmd_valid) begin
      case (cmd)
        stim_pkg::CMD_SET_ONE:   out_nxt = out_r | bit_mask;
        stim_pkg::CMD_CLEAR_ONE: out_nxt = out_r & ~bit_mask;
        stim_pkg::CMD_WRITE_ALL: out_nxt = cmd_byte;
        default:                 out_nxt = out_r;
      endcase
    end
  end

  // output latch; patterns and pulses come from command sequences
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) out_r <= stim_pkg::OUTPUTS_RESET;
    else        out_r <= out_nxt;
  end
  assign stim_out   = out_r;
  // strobe trigger only on a real level change
  assign sif.change = (out_nxt != out_r);

  strobe_gen #(.CYCLES(STROBE_CYCLES)) u_strobe (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .sif      (sif),
    .strobe_n (change_strobe_n)
  );

  // set once any command has been taken; cleared again by reset
  logic       seen_cmd_r; // a command arrived since reset
  logic       seen_cmd_nxt;
  always_comb begin
    seen_cmd_nxt = seen_cmd_r;
    if (cmd_valid) begin
      seen_cmd_nxt = 1'b1; // first command ends the reset state
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) seen_cmd_r <= 1'b0;
    else        seen_cmd_r <= seen_cmd_nxt;
  end

  // cycles since the last level change, saturating at the strobe width;
  // only the assertions read it, so the pulse is judged from outside
  localparam int            QW         = $clog2(STROBE_CYCLES + 1);
  localparam logic [QW-1:0] QUIET_FULL = QW'(STROBE_CYCLES);
  logic [QW-1:0] quiet_r;   // cycles since the last change
  logic [QW-1:0] quiet_nxt;
  always_comb begin
    quiet_nxt = quiet_r;
    if (sif.change) begin
      quiet_nxt = '0; // a change starts the count again
    end else if (quiet_r != QUIET_FULL) begin
      quiet_nxt = quiet_r + 1'b1; // count up to the full width
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) quiet_r <= QUIET_FULL; // quiet since reset
    else        quiet_r <= quiet_nxt;
  end

  // assertions on the output latch
  // no command, no movement
  a_hold_level: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !cmd_valid |=> $stable(stim_out))
    else $error("outputs moved with no command");
  // an empty command is taken but changes nothing
  a_none_ignored: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    cmd_valid && cmd == stim_pkg::CMD_NONE |=> $stable(stim_out))
    else $error("empty command moved outputs");
  // set drives the named output high
  a_set_one: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    cmd_valid && cmd == stim_pkg::CMD_SET_ONE |=>
      stim_out == ($past(stim_out) | (8'h01 << $past(cmd_index))))
    else $error("set command wrong");
  // clear drives the named output low
  a_clear_one: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    cmd_valid && cmd == stim_pkg::CMD_CLEAR_ONE |=>
      stim_out == ($past(stim_out) & ~(8'h01 << $past(cmd_index))))
    else $error("clear command wrong");
  // per output: a single-bit command aimed elsewhere leaves it alone,
  // and a byte write puts its own byte bit on it
  for (genvar b = 0; b < stim_pkg::NUM_OUTPUTS; b++) begin : g_bit
    a_bit_other: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      cmd_valid && cmd inside {stim_pkg::CMD_SET_ONE,
        stim_pkg::CMD_CLEAR_ONE} && cmd_index != 3'(b) |=>
        stim_out[b] == $past(stim_out[b]))
      else $error("other output disturbed");
    a_bit_byte: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      cmd_valid && cmd == stim_pkg::CMD_WRITE_ALL |=>
        stim_out[b] == $past(cmd_byte[b]))
      else $error("byte bit not on its output");
  end
  // a byte write lands on all eight outputs at one edge
  a_write_all: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    cmd_valid && cmd == stim_pkg::CMD_WRITE_ALL |=>
      stim_out == $past(cmd_byte))
    else $error("byte write wrong");
  // the worked example: 84 drives outputs 7 and 2 only
  a_byte_map: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    cmd_valid && cmd == stim_pkg::CMD_WRITE_ALL && cmd_byte == 8'h84 |=>
      stim_out[7] && stim_out[2] && stim_out[6:3] == 4'h0 &&
      stim_out[1:0] == 2'h0)
    else $error("byte bit order wrong");
  // a clear right after a set on the same output wins, leaving it low
  a_in_order: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    cmd_valid && cmd == stim_pkg::CMD_SET_ONE ##1
    cmd_valid && cmd == stim_pkg::CMD_CLEAR_ONE &&
    cmd_index == $past(cmd_index) |=> !stim_out[$past(cmd_index)])
    else $error("commands applied out of order");
  // commands are never refused
  a_ready_high: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    cmd_valid |-> cmd_ready)
    else $error("command refused");

  // assertions on the strobe
  // a level change shows the strobe low at once
  a_change_strobe: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $changed(stim_out) |-> !change_strobe_n)
    else $error("no strobe on change");
  // low for a full width after the last change
  a_strobe_low: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    quiet_r != QUIET_FULL |-> sif.busy && !change_strobe_n)
    else $error("strobe high too soon");
  // high again once a full width has passed quietly
  a_strobe_idle: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    quiet_r == QUIET_FULL |-> change_strobe_n)
    else $error("strobe low with no change");
  // outputs low and strobe high until the first command
  a_reset_quiet: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !seen_cmd_r |->
      stim_out == stim_pkg::OUTPUTS_RESET && change_strobe_n)
    else $error("reset state not kept");

  // covers for the main scenarios
  c_set_clear: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_valid && cmd == stim_pkg::CMD_SET_ONE ##1
    cmd_valid && cmd == stim_pkg::CMD_CLEAR_ONE);
  c_write_all: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_valid && cmd == stim_pkg::CMD_WRITE_ALL);
  c_strobe: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(change_strobe_n));
  c_no_change: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_valid && cmd == stim_pkg::CMD_SET_ONE && !sif.change);
endmodule : stimulus_output_generator

// *** dv/target_inputs.sv ***
`timescale 1ns/1ps
// target input side: times each strobe low pulse it sees
module target_inputs (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  stim_in,
  input  wire logic        strobe_n,
  output logic      [15:0] low_cycles,
  output logic      [7:0]  latched
);
  logic [15:0] run_r; // low cycles so far
  // count while low, keep width of last finished pulse; take the
  // inputs in as the strobe goes back high, as a target would
  always_ff @(posedge clk_sys) begin
    run_r <= strobe_n ? 16'h0000 : run_r + 16'h0001;
    if (strobe_n && run_r != 16'h0000) begin
      low_cycles <= run_r;
      latched    <= stim_in;
    end
  end
endmodule : target_inputs

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  localparam int SC = 4; // shortened strobe width
  logic           clk_sys = 1'h0;
  logic           resetn = 1'h0;
  stim_pkg::cmd_t cmd = stim_pkg::CMD_NONE;
  logic           cmd_valid = 1'h0;
  logic [2:0]     cmd_index = 3'h0;
  logic [7:0]     cmd_byte = 8'h00;
  logic [7:0]     stim_out;
  logic           strb_n;
  logic [15:0]    low_cycles;
  logic           rdy;
  logic [7:0]     latched;
  int             n_errors = 0;
  int             num_checks = 0;
  int             cyc = 0;
  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;
  stimulus_output_generator #(.STROBE_CYCLES(SC)) stimulus_output_generator_i (
    .clk_sys(clk_sys), .resetn(resetn), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_index(cmd_index), .cmd_byte(cmd_byte), .cmd_ready(rdy),
    .stim_out(stim_out), .change_strobe_n(strb_n));
  target_inputs target_inputs_i (.clk_sys(clk_sys), .stim_in(stim_out),
    .strobe_n(strb_n), .low_cycles(low_cycles), .latched(latched));
  task automatic end_of_test;
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one command from a falling edge; valid stays up for back to back use
  task automatic go(input stim_pkg::cmd_t c, input logic [2:0] i,
                    input logic [7:0] b);
    cmd = c;
    cmd_index = i;
    cmd_byte = b;
    cmd_valid = 1'h1;
    @(negedge clk_sys);
  endtask : go
  task automatic idle(input int n);
    cmd_valid = 1'h0;
    repeat (n) @(negedge clk_sys);
  endtask : idle
  task automatic t_byte;
    go(stim_pkg::CMD_WRITE_ALL, 3'h0, 8'h84);
    chk(stim_out, 16'h0084);
    chk(strb_n, 16'h0000);
    idle(SC + 2);
    chk(low_cycles, SC);
    chk(stim_out, 16'h0084);
  endtask : t_byte
  task automatic t_group;
    go(stim_pkg::CMD_WRITE_ALL, 3'h0, 8'h0A);
    chk(stim_out, 16'h000A);
    chk(rdy, 16'h0001);
    go(stim_pkg::CMD_SET_ONE, 3'h0, 8'h00);
    chk(stim_out, 16'h000B);
    go(stim_pkg::CMD_CLEAR_ONE, 3'h1, 8'h00);
    chk(stim_out, 16'h0009);
    go(stim_pkg::CMD_CLEAR_ONE, 3'h3, 8'h00);
    chk(stim_out, 16'h0001);
    idle(SC + 2);
    chk(low_cycles, SC + 3);
  endtask : t_group
  task automatic t_same;
    go(stim_pkg::CMD_SET_ONE, 3'h0, 8'h00);
    go(stim_pkg::CMD_NONE, 3'h2, 8'hFF);
    idle(1);
    chk(strb_n, 16'h0001);
    chk(stim_out, 16'h0001);
  endtask : t_same
  task automatic t_pulse;
    go(stim_pkg::CMD_SET_ONE, 3'h3, 8'h00);
    chk(stim_out, 16'h0009);
    go(stim_pkg::CMD_CLEAR_ONE, 3'h3, 8'h00);
    chk(stim_out, 16'h0001);
    idle(SC + 2);
    chk(low_cycles, SC + 1);
    chk(latched, 16'h0001);
  endtask : t_pulse
  task automatic t_pattern;
    repeat (3) begin
      go(stim_pkg::CMD_WRITE_ALL, 3'h0, 8'h55);
      chk(stim_out, 16'h0055);
      go(stim_pkg::CMD_WRITE_ALL, 3'h0, 8'hAA);
      chk(stim_out, 16'h00AA);
    end
    idle(SC + 2);
    chk(low_cycles, SC + 5);
    chk(latched, 16'h00AA);
  endtask : t_pattern
  // reset in the middle of a strobe pulse
  task automatic t_reset;
    go(stim_pkg::CMD_SET_ONE, 3'h6, 8'h00);
    cmd_valid = 1'h0;
    resetn = 1'h0;
    @(negedge clk_sys);
    chk(stim_out, 16'h0000);
    chk(strb_n, 16'h0001);
    repeat (2) @(negedge clk_sys);
    resetn = 1'h1;
    repeat (3) @(negedge clk_sys);
    chk(stim_out, 16'h0000);
    chk(strb_n, 16'h0001);
    go(stim_pkg::CMD_SET_ONE, 3'h5, 8'h00);
    chk(stim_out, 16'h0020);
    chk(strb_n, 16'h0000);
    idle(SC + 2);
    chk(low_cycles, SC);
    chk(latched, 16'h0020);
  endtask : t_reset
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 500) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(negedge clk_sys);
    resetn = 1'h1;
    chk(stim_out, 16'h0000);
    chk(strb_n, 16'h0001);
    repeat (3) @(negedge clk_sys);
    t_byte();
    t_group();
    t_same();
    t_pulse();
    t_pattern();
    t_reset();
    end_of_test();
  end
endmodule : testbench
